// file: design/event_action_scheduler_regs.sv
`timescale 1ns/1ps
`default_nettype none
module event_action_scheduler_regs (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] page,
  input  wire logic [7:0] sub_addr,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  output logic            rd_valid,
  input  wire logic [7:0] rtc_minute,
  input  wire logic [7:0] rtc_hour,
  input  wire logic [7:0] rtc_day_of_month,
  input  wire logic [7:0] rtc_month,
  input  wire logic [7:0] rtc_year,
  input  wire logic       rtc_minute_tick,
  output logic            host_power_on,
  output logic            aux_rail_on,
  output logic            relay_set,
  output logic      [3:0] entry_running
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic digits_ok(input logic [7:0] b);
    digits_ok = (b[7:4] <= 4'h9) && (b[3:0] <= 4'h9);
  endfunction

  function automatic logic [6:0] bcd2_bin(input logic [7:0] b);
    // widen first so the product never wraps at four bits
    bcd2_bin = 7'(b[7:4]) * 7'h0A + 7'(b[3:0]);
  endfunction

  function automatic logic bcd2_in(input logic [7:0] b, input logic [6:0] lo, input logic [6:0] hi);
    bcd2_in = digits_ok(b) && (bcd2_bin(b) >= lo) && (bcd2_bin(b) <= hi);
  endfunction

  function automatic logic [13:0] bcd4_bin(input logic [15:0] w);
    bcd4_bin = 14'(w[15:12]) * 14'h3E8 + 14'(w[11:8]) * 14'h064
             + 14'(w[7:4]) * 14'h00A + 14'(w[3:0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0]  entry_selector;
  logic [3:0]  entry_active;

  logic [7:0]  start_minute       [sched_pkg::ENTRIES];
  logic [7:0]  start_hour         [sched_pkg::ENTRIES];
  logic [7:0]  start_day_of_month [sched_pkg::ENTRIES];
  logic [7:0]  start_month        [sched_pkg::ENTRIES];
  logic [7:0]  start_year         [sched_pkg::ENTRIES];

  logic [15:0] action_duration_minutes [sched_pkg::ENTRIES];
  logic [15:0] action_repeat_minutes   [sched_pkg::ENTRIES];

  logic [3:0]  host_power_action;
  logic [3:0]  aux_rail_action;
  logic [3:0]  relay_set_action;

  logic [7:0]  entry_fault [sched_pkg::ENTRIES];
  logic [3:0]  running;
  logic [7:0]  next_rd_data;

  // page and offset decode
  wire logic pg_common = (page == sched_pkg::COMMON_PAGE);
  wire logic pg_start  = (page == sched_pkg::START_PAGE);
  wire logic pg_run    = (page == sched_pkg::RUN_PAGE);
  wire logic pg_action = (page == sched_pkg::ACTION_PAGE);

  wire logic wr_sel    = wr_en && pg_common && (sub_addr == sched_pkg::ENTRY_SELECTOR_OFS);

  wire logic wr_active = wr_en && pg_start  && (sub_addr == sched_pkg::ACTIVE_OFS);
  wire logic wr_min    = wr_en && pg_start  && (sub_addr == sched_pkg::START_MINUTE_OFS);
  wire logic wr_hour   = wr_en && pg_start  && (sub_addr == sched_pkg::START_HOUR_OFS);
  wire logic wr_day    = wr_en && pg_start  && (sub_addr == sched_pkg::START_DAY_OF_MONTH_OFS);
  wire logic wr_month  = wr_en && pg_start  && (sub_addr == sched_pkg::START_MONTH_OFS);
  wire logic wr_year   = wr_en && pg_start  && (sub_addr == sched_pkg::START_YEAR_OFS);

  wire logic wr_dur_lo = wr_en && pg_run    && (sub_addr == sched_pkg::DURATION_LO_OFS);
  wire logic wr_dur_hi = wr_en && pg_run    && (sub_addr == sched_pkg::DURATION_HI_OFS);
  wire logic wr_rep_lo = wr_en && pg_run    && (sub_addr == sched_pkg::REPEAT_LO_OFS);
  wire logic wr_rep_hi = wr_en && pg_run    && (sub_addr == sched_pkg::REPEAT_HI_OFS);

  wire logic wr_host   = wr_en && pg_action && (sub_addr == sched_pkg::HOST_POWER_ACTION_OFS);
  wire logic wr_aux    = wr_en && pg_action && (sub_addr == sched_pkg::AUX_RAIL_ACTION_OFS);
  wire logic wr_relay  = wr_en && pg_action && (sub_addr == sched_pkg::RELAY_SET_ACTION_OFS);

  // only the two documented codes move a flag; anything else leaves it alone
  wire logic flag_on   = (wr_data == sched_pkg::FLAG_ON);
  wire logic flag_off  = (wr_data == sched_pkg::FLAG_OFF);
  wire logic flag_cmd  = flag_on || flag_off;
  wire logic act_cmd   = (wr_data == sched_pkg::ACTIVE_RUN) || (wr_data == sched_pkg::ACTIVE_STOP);

  ////////////////////////////////////////////////////////////////////////////
  // selector and single-bit controls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      entry_selector    <= sched_pkg::SELECTOR_RST[1:0];
      entry_active      <= 4'h0;
      host_power_action <= 4'h0;
      aux_rail_action   <= 4'h0;
      relay_set_action  <= 4'h0;
    end else begin
      if (wr_sel && (wr_data <= sched_pkg::ENTRY_MAX)) begin
        entry_selector <= wr_data[1:0];
      end

      if (wr_active && act_cmd) begin
        entry_active[entry_selector] <= (wr_data == sched_pkg::ACTIVE_RUN);
      end

      if (wr_host && flag_cmd) begin
        host_power_action[entry_selector] <= flag_on;
      end

      if (wr_aux && flag_cmd) begin
        aux_rail_action[entry_selector] <= flag_on;
      end

      if (wr_relay && flag_cmd) begin
        relay_set_action[entry_selector] <= flag_on;
      end
    end
  end

  // time, duration and repeat fields of the selected entry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < sched_pkg::ENTRIES; i++) begin
        start_minute[i]            <= sched_pkg::START_MINUTE_RST;
        start_hour[i]              <= sched_pkg::START_HOUR_RST;
        start_day_of_month[i]      <= sched_pkg::START_DAY_RST;
        start_month[i]             <= sched_pkg::START_MONTH_RST;
        start_year[i]              <= sched_pkg::START_YEAR_RST;
        action_duration_minutes[i] <= sched_pkg::DURATION_RST;
        action_repeat_minutes[i]   <= sched_pkg::REPEAT_RST;
      end
    end else begin
      if (wr_min) begin
        start_minute[entry_selector] <= wr_data;
      end

      if (wr_hour) begin
        start_hour[entry_selector] <= wr_data;
      end

      if (wr_day) begin
        start_day_of_month[entry_selector] <= wr_data;
      end

      if (wr_month) begin
        start_month[entry_selector] <= wr_data;
      end

      if (wr_year) begin
        start_year[entry_selector] <= wr_data;
      end

      if (wr_dur_lo) begin
        action_duration_minutes[entry_selector][7:0] <= wr_data;
      end

      if (wr_dur_hi) begin
        action_duration_minutes[entry_selector][15:8] <= wr_data;
      end

      if (wr_rep_lo) begin
        action_repeat_minutes[entry_selector][7:0] <= wr_data;
      end

      if (wr_rep_hi) begin
        action_repeat_minutes[entry_selector][15:8] <= wr_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-entry fault bytes and run state machines
  for (genvar e = 0; e < sched_pkg::ENTRIES; e++) begin : g_entry
    sched_pkg::entry_state_t state;
    logic [13:0] remain;
    logic [13:0] rep_left;

    wire logic [13:0] dur_bin = bcd4_bin(action_duration_minutes[e]);
    wire logic [13:0] rep_bin = bcd4_bin(action_repeat_minutes[e]);
    wire logic dur_ok = digits_ok(action_duration_minutes[e][15:8])
                     && digits_ok(action_duration_minutes[e][7:0]) && (dur_bin != 14'd0);
    wire logic rep_ok = digits_ok(action_repeat_minutes[e][15:8]) && digits_ok(action_repeat_minutes[e][7:0]);
    wire logic cfg_ok = (entry_fault[e] == 8'h00);
    wire logic repeats = (rep_bin != 14'd0);

    // a faulty entry never starts from idle; one already running is not stopped by a fault and still restarts
    wire logic time_hit = (start_minute[e] == rtc_minute) && (start_hour[e] == rtc_hour)
                       && (start_day_of_month[e] == rtc_day_of_month) && (start_month[e] == rtc_month)
                       && (start_year[e] == rtc_year) && cfg_ok;

    assign entry_fault[e][sched_pkg::FAULT_MINUTE]   = !bcd2_in(start_minute[e], 7'd0, 7'd59);
    assign entry_fault[e][sched_pkg::FAULT_HOUR]     = !bcd2_in(start_hour[e], 7'd0, 7'd23);
    assign entry_fault[e][sched_pkg::FAULT_DAY]      = !bcd2_in(start_day_of_month[e], 7'd1, 7'd31);
    assign entry_fault[e][sched_pkg::FAULT_MONTH]    = !bcd2_in(start_month[e], 7'd1, 7'd12);
    assign entry_fault[e][sched_pkg::FAULT_YEAR]     = !bcd2_in(start_year[e], 7'd0, 7'd99);
    assign entry_fault[e][sched_pkg::FAULT_DURATION] = !dur_ok;
    assign entry_fault[e][sched_pkg::FAULT_REPEAT]   = !rep_ok;
    assign entry_fault[e][7]                         = 1'b0;

    assign running[e] = (state == sched_pkg::ST_RUN);

    // state advances on the rtc minute tick only, except that an inactive entry drops to idle at once
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        state    <= sched_pkg::ST_IDLE;
        remain   <= 14'd0;
        rep_left <= 14'd0;
      end else if (!entry_active[e]) begin
        // inactive wins over a tick; a stop written in the tick cycle takes hold one cycle later
        state <= sched_pkg::ST_IDLE;
      end else if (rtc_minute_tick) begin
        case (state)
          sched_pkg::ST_IDLE: begin
            if (time_hit) begin
              state    <= sched_pkg::ST_RUN;
              remain   <= dur_bin;
              rep_left <= rep_bin;
            end
          end
          sched_pkg::ST_RUN, sched_pkg::ST_PAUSE: begin
            // a new period restarts the run even while it is still on
            if (repeats && (rep_left <= 14'd1)) begin
              state    <= sched_pkg::ST_RUN;
              remain   <= dur_bin;
              rep_left <= rep_bin;
            end else begin
              rep_left <= rep_left - 14'd1;
              if (state == sched_pkg::ST_RUN) begin
                remain <= remain - 14'd1;
                if (remain <= 14'd1) begin
                  state <= repeats ? sched_pkg::ST_PAUSE : sched_pkg::ST_IDLE;
                end
              end
            end
          end
          default: begin
            state <= sched_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // action drive: power-up is the only class, so no class field exists
  wire logic next_host  = |(running & host_power_action);
  wire logic next_aux   = |(running & aux_rail_action);
  wire logic next_relay = |(running & relay_set_action);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_power_on <= 1'b0;
      aux_rail_on   <= 1'b0;
      relay_set     <= 1'b0;
      entry_running <= 4'h0;
    end else begin
      host_power_on <= next_host;
      aux_rail_on   <= next_aux;
      relay_set     <= next_relay;
      entry_running <= running;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped locations and the empty events page read zero
  always_comb begin
    next_rd_data = 8'h00;
    if (pg_common && (sub_addr == sched_pkg::ENTRY_SELECTOR_OFS)) begin
      next_rd_data = {6'h00, entry_selector};
    end else if (pg_start && (sub_addr == sched_pkg::ACTIVE_OFS)) begin
      next_rd_data = entry_active[entry_selector] ? sched_pkg::ACTIVE_RUN : sched_pkg::ACTIVE_STOP;
    end else if (pg_start && (sub_addr == sched_pkg::START_MINUTE_OFS)) begin
      next_rd_data = start_minute[entry_selector];
    end else if (pg_start && (sub_addr == sched_pkg::START_HOUR_OFS)) begin
      next_rd_data = start_hour[entry_selector];
    end else if (pg_start && (sub_addr == sched_pkg::START_DAY_OF_MONTH_OFS)) begin
      next_rd_data = start_day_of_month[entry_selector];
    end else if (pg_start && (sub_addr == sched_pkg::START_MONTH_OFS)) begin
      next_rd_data = start_month[entry_selector];
    end else if (pg_start && (sub_addr == sched_pkg::START_YEAR_OFS)) begin
      next_rd_data = start_year[entry_selector];
    end else if (pg_start && (sub_addr == sched_pkg::START_PAGE_FAULT_OFS)) begin
      next_rd_data = entry_fault[entry_selector];
    end else if (pg_run && (sub_addr == sched_pkg::RUN_PAGE_FAULT_OFS)) begin
      next_rd_data = entry_fault[entry_selector];
    end else if (pg_run && (sub_addr == sched_pkg::DURATION_LO_OFS)) begin
      next_rd_data = action_duration_minutes[entry_selector][7:0];
    end else if (pg_run && (sub_addr == sched_pkg::DURATION_HI_OFS)) begin
      next_rd_data = action_duration_minutes[entry_selector][15:8];
    end else if (pg_run && (sub_addr == sched_pkg::REPEAT_LO_OFS)) begin
      next_rd_data = action_repeat_minutes[entry_selector][7:0];
    end else if (pg_run && (sub_addr == sched_pkg::REPEAT_HI_OFS)) begin
      next_rd_data = action_repeat_minutes[entry_selector][15:8];
    end else if (pg_action && (sub_addr == sched_pkg::HOST_POWER_ACTION_OFS)) begin
      next_rd_data = {7'h00, host_power_action[entry_selector]};
    end else if (pg_action && (sub_addr == sched_pkg::AUX_RAIL_ACTION_OFS)) begin
      next_rd_data = {7'h00, aux_rail_action[entry_selector]};
    end else if (pg_action && (sub_addr == sched_pkg::RELAY_SET_ACTION_OFS)) begin
      next_rd_data = {7'h00, relay_set_action[entry_selector]};
    end
  end

  // read data holds until the next read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= next_rd_data;
      end
    end
  end

endmodule
`default_nettype wire

// file: design/sched_pkg.sv
`default_nettype none
package sched_pkg;

  // page addresses of the scheduler command set
  localparam logic [7:0] COMMON_PAGE = 8'h6B;
  localparam logic [7:0] START_PAGE  = 8'h6C;
  localparam logic [7:0] RUN_PAGE    = 8'h6D;
  localparam logic [7:0] EVENT_PAGE  = 8'h6E;
  localparam logic [7:0] ACTION_PAGE = 8'h6F;

  // common page
  localparam logic [7:0] ENTRY_SELECTOR_OFS = 8'h16;

  // start-time page
  localparam logic [7:0] ACTIVE_OFS             = 8'h00;
  localparam logic [7:0] START_MINUTE_OFS       = 8'h01;
  localparam logic [7:0] START_HOUR_OFS         = 8'h02;
  localparam logic [7:0] START_DAY_OF_MONTH_OFS = 8'h03;
  localparam logic [7:0] START_MONTH_OFS        = 8'h04;
  localparam logic [7:0] START_YEAR_OFS         = 8'h05;
  localparam logic [7:0] START_PAGE_FAULT_OFS   = 8'h06;

  // running-time page, words low byte first
  localparam logic [7:0] RUN_PAGE_FAULT_OFS    = 8'h00;
  localparam logic [7:0] DURATION_LO_OFS       = 8'h01;
  localparam logic [7:0] DURATION_HI_OFS       = 8'h02;
  localparam logic [7:0] REPEAT_LO_OFS         = 8'h03;
  localparam logic [7:0] REPEAT_HI_OFS         = 8'h04;

  // actions page
  localparam logic [7:0] HOST_POWER_ACTION_OFS = 8'h00;
  localparam logic [7:0] AUX_RAIL_ACTION_OFS   = 8'h01;
  localparam logic [7:0] RELAY_SET_ACTION_OFS  = 8'h02;

  // written codes
  localparam logic [7:0] ACTIVE_STOP = 8'h00;
  localparam logic [7:0] ACTIVE_RUN  = 8'hFF;
  localparam logic [7:0] FLAG_OFF    = 8'h00;
  localparam logic [7:0] FLAG_ON     = 8'h01;
  localparam logic [7:0] ENTRY_MAX   = 8'h03;

  // reset values
  localparam logic [7:0]  SELECTOR_RST     = 8'h00;
  localparam logic [7:0]  START_MINUTE_RST = 8'h00;
  localparam logic [7:0]  START_HOUR_RST   = 8'h00;
  localparam logic [7:0]  START_DAY_RST    = 8'h01;
  localparam logic [7:0]  START_MONTH_RST  = 8'h01;
  localparam logic [7:0]  START_YEAR_RST   = 8'h00;
  localparam logic [15:0] DURATION_RST     = 16'h0001;
  localparam logic [15:0] REPEAT_RST       = 16'h0000;

  // fault byte bit positions
  localparam int FAULT_MINUTE   = 0;
  localparam int FAULT_HOUR     = 1;
  localparam int FAULT_DAY      = 2;
  localparam int FAULT_MONTH    = 3;
  localparam int FAULT_YEAR     = 4;
  localparam int FAULT_DURATION = 5;
  localparam int FAULT_REPEAT   = 6;

  localparam int ENTRIES = 4;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_PAUSE} entry_state_t;

endpackage
`default_nettype wire

// file: test/event_action_scheduler_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module event_action_scheduler_regs_checker (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] page,
  input wire logic [7:0] sub_addr,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid,
  input wire logic       rtc_minute_tick,
  input wire logic       host_power_on,
  input wire logic       aux_rail_on,
  input wire logic       relay_set,
  input wire logic [3:0] entry_running
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  logic rd_flag;
  logic rd_sel;
  logic rd_act;
  logic rd_fault;
  assign rd_flag  = rd_en && page == sched_pkg::ACTION_PAGE && sub_addr <= sched_pkg::RELAY_SET_ACTION_OFS;
  assign rd_sel   = rd_en && page == sched_pkg::COMMON_PAGE && sub_addr == sched_pkg::ENTRY_SELECTOR_OFS;
  assign rd_act   = rd_en && page == sched_pkg::START_PAGE && sub_addr == sched_pkg::ACTIVE_OFS;
  assign rd_fault = rd_en && page == sched_pkg::START_PAGE && sub_addr == sched_pkg::START_PAGE_FAULT_OFS;
  ////////////////////////////////////////////////////////////
  a_read_answered: assert property (rd_en |=> rd_valid)
    else $error("read strobe not answered next cycle");
  a_no_stray_valid: assert property (!rd_en |=> !rd_valid)
    else $error("read valid without a read strobe");
  a_read_data_holds: assert property (!rd_en |=> $stable(rd_data))
    else $error("read data moved without a read");
  a_fault_top_clear: assert property (rd_fault |=> rd_data[7] == 1'b0)
    else $error("fault byte bit 7 set");
  a_flag_two_values: assert property (rd_flag |=> rd_data[7:1] == 7'h00)
    else $error("action flag reads other than 0 or 1");
  a_selector_range: assert property (rd_sel |=> rd_data <= sched_pkg::ENTRY_MAX)
    else $error("selector reads above 3");
  a_active_two_codes: assert property (rd_act |=> rd_data == 8'h00 || rd_data == 8'hFF)
    else $error("activation byte reads other than 00 or FF");
  // a run may only begin two cycles after a minute tick
  a_run_needs_tick: assert property ((entry_running & ~$past(entry_running)) != 4'h0 |-> $past(rtc_minute_tick, 2))
    else $error("entry started without a minute tick");
  a_host_in_run: assert property (host_power_on |-> entry_running != 4'h0)
    else $error("host power on with no entry running");
  a_aux_in_run: assert property (aux_rail_on |-> entry_running != 4'h0)
    else $error("aux rail on with no entry running");
  a_relay_in_run: assert property (relay_set |-> entry_running != 4'h0)
    else $error("relay set with no entry running");
  c_read: cover property (rd_valid);
  c_host_on: cover property ($rose(host_power_on));
  c_run_end: cover property ($fell(entry_running[0]));
  c_action_write: cover property (wr_en && page == sched_pkg::ACTION_PAGE);
endmodule
bind event_action_scheduler_regs event_action_scheduler_regs_checker u_chk (
  .clk(clk), .rst_n(rst_n), .page(page), .sub_addr(sub_addr), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .rd_valid(rd_valid), .rtc_minute_tick(rtc_minute_tick), .host_power_on(host_power_on),
  .aux_rail_on(aux_rail_on), .relay_set(relay_set), .entry_running(entry_running)
);
`default_nettype wire

// file: test/event_action_scheduler_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module event_action_scheduler_regs_test;
  logic       clk, rst_n, wr_en, rd_en, rd_valid, rtc_minute_tick, host_power_on, aux_rail_on, relay_set, ok;
  logic [7:0] page, sub_addr, wr_data, rd_data, got;
  logic [7:0] rtc_minute, rtc_hour, rtc_day_of_month, rtc_month, rtc_year;
  logic [3:0] entry_running;
  logic [7:0] fld [4][5];
  int         n_mismatch = 0;
  int         total_checks = 0;
  localparam logic [7:0] START_DEF [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
  localparam logic [7:0] RUN_DEF [5] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  always #2.5 clk = ~clk;
  event_action_scheduler_regs dut (.clk(clk), .rst_n(rst_n), .page(page), .sub_addr(sub_addr), .wr_en(wr_en),
    .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid), .rtc_minute(rtc_minute),
    .rtc_hour(rtc_hour), .rtc_day_of_month(rtc_day_of_month), .rtc_month(rtc_month), .rtc_year(rtc_year),
    .rtc_minute_tick(rtc_minute_tick), .host_power_on(host_power_on), .aux_rail_on(aux_rail_on),
    .relay_set(relay_set), .entry_running(entry_running));
  host_model host (.clk(clk), .page(page), .sub_addr(sub_addr), .wr_en(wr_en), .wr_data(wr_data),
    .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid));
  ////////////////////////////////////////////////////////////
  task automatic summarize();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string what);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e, input string what);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, g, e);
    end
  endtask
  task automatic expect_reg(input logic [7:0] p, input logic [7:0] a, input logic [7:0] e);
    host.read_reg(p, a, got, ok);
    chk_bit(ok, 1'b1, "read answer");
    chk_byte(got, e, "read data");
  endtask
  // minute is set with the tick; outputs land two cycles after the tick edge
  task automatic tick(input logic [7:0] m);
    @(posedge clk);
    rtc_minute <= m;
    rtc_minute_tick <= 1'b1;
    @(posedge clk);
    rtc_minute_tick <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic run_is(input logic [3:0] r, input logic h, input logic a, input logic s);
    chk_byte({4'h0, entry_running}, {4'h0, r}, "entry running");
    chk_bit(host_power_on, h, "host power");
    chk_bit(aux_rail_on, a, "aux rail");
    chk_bit(relay_set, s, "relay");
  endtask
  function automatic logic [7:0] bcd(input int n);
    return {4'(n / 10), 4'(n % 10)};
  endfunction
  function automatic logic [7:0] rand_field(input int k);
    case (k)
      0: return bcd($urandom_range(59));
      1: return bcd($urandom_range(23));
      2: return bcd($urandom_range(31, 1));
      3: return bcd($urandom_range(12, 1));
      default: return bcd($urandom_range(99));
    endcase
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    rtc_minute_tick = 1'b0;
    {rtc_minute, rtc_hour, rtc_day_of_month, rtc_month, rtc_year} = 40'h0;
    void'($urandom(44720));
    repeat (2) @(posedge clk);
    #1;
    run_is(4'h0, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    rst_n <= 1'b1;
    expect_reg(sched_pkg::COMMON_PAGE, sched_pkg::ENTRY_SELECTOR_OFS, 8'h00);
    for (int i = 0; i < 7; i++) expect_reg(sched_pkg::START_PAGE, 8'(i), START_DEF[i]);
    for (int i = 0; i < 5; i++) expect_reg(sched_pkg::RUN_PAGE, 8'(i), RUN_DEF[i]);
    for (int i = 0; i < 3; i++) expect_reg(sched_pkg::ACTION_PAGE, 8'(i), 8'h00);
    for (int e = 0; e < 4; e++) begin
      host.write_reg(sched_pkg::COMMON_PAGE, sched_pkg::ENTRY_SELECTOR_OFS, 8'(e));
      for (int k = 0; k < 5; k++) begin
        fld[e][k] = rand_field(k);
        host.write_reg(sched_pkg::START_PAGE, 8'(k + 1), fld[e][k]);
      end
    end
    for (int e = 0; e < 4; e++) begin
      host.write_reg(sched_pkg::COMMON_PAGE, sched_pkg::ENTRY_SELECTOR_OFS, 8'(e));
      for (int k = 0; k < 5; k++) expect_reg(sched_pkg::START_PAGE, 8'(k + 1), fld[e][k]);
      expect_reg(sched_pkg::START_PAGE, sched_pkg::START_PAGE_FAULT_OFS, 8'h00);
    end
    // refused writes on entry 3, which is left faulty and inactive
    host.write_reg(sched_pkg::COMMON_PAGE, sched_pkg::ENTRY_SELECTOR_OFS, 8'h04);
    expect_reg(sched_pkg::COMMON_PAGE, sched_pkg::ENTRY_SELECTOR_OFS, 8'h03);
    host.write_reg(sched_pkg::START_PAGE, sched_pkg::ACTIVE_OFS, 8'h55);
    expect_reg(sched_pkg::START_PAGE, sched_pkg::ACTIVE_OFS, 8'h00);
    host.write_reg(sched_pkg::ACTION_PAGE, sched_pkg::AUX_RAIL_ACTION_OFS, 8'h02);
    expect_reg(sched_pkg::ACTION_PAGE, sched_pkg::AUX_RAIL_ACTION_OFS, 8'h00);
    host.write_reg(sched_pkg::START_PAGE, sched_pkg::START_PAGE_FAULT_OFS, 8'h7F);
    expect_reg(sched_pkg::START_PAGE, sched_pkg::START_PAGE_FAULT_OFS, 8'h00);
    host.write_reg(sched_pkg::START_PAGE, sched_pkg::START_MINUTE_OFS, 8'h60);
    host.write_reg(sched_pkg::RUN_PAGE, sched_pkg::DURATION_LO_OFS, 8'h00);
    host.write_reg(sched_pkg::RUN_PAGE, sched_pkg::REPEAT_LO_OFS, 8'h0A);
    expect_reg(sched_pkg::START_PAGE, sched_pkg::START_PAGE_FAULT_OFS, 8'h61);
    expect_reg(sched_pkg::RUN_PAGE, sched_pkg::RUN_PAGE_FAULT_OFS, 8'h61);
    host.write_reg(sched_pkg::RUN_PAGE, sched_pkg::DURATION_HI_OFS, 8'h12);
    host.write_reg(sched_pkg::RUN_PAGE, sched_pkg::REPEAT_HI_OFS, 8'h98);
    expect_reg(sched_pkg::RUN_PAGE, sched_pkg::DURATION_HI_OFS, 8'h12);
    expect_reg(sched_pkg::RUN_PAGE, sched_pkg::REPEAT_HI_OFS, 8'h98);
    // once-only run on entry 0, clock moved off the start minute afterwards
    host.write_reg(sched_pkg::COMMON_PAGE, sched_pkg::ENTRY_SELECTOR_OFS, 8'h00);
    host.write_reg(sched_pkg::RUN_PAGE, sched_pkg::DURATION_LO_OFS, 8'h02);
    host.write_reg(sched_pkg::ACTION_PAGE, sched_pkg::HOST_POWER_ACTION_OFS, sched_pkg::FLAG_ON);
    host.write_reg(sched_pkg::START_PAGE, sched_pkg::ACTIVE_OFS, sched_pkg::ACTIVE_RUN);
    expect_reg(sched_pkg::START_PAGE, sched_pkg::ACTIVE_OFS, 8'hFF);
    @(posedge clk);
    rtc_hour <= fld[0][1];
    rtc_day_of_month <= fld[0][2];
    rtc_month <= fld[0][3];
    rtc_year <= fld[0][4];
    tick(fld[0][0]);
    run_is(4'h1, 1'b1, 1'b0, 1'b0);
    tick(8'hAA);
    run_is(4'h1, 1'b1, 1'b0, 1'b0);
    tick(8'hAA);
    run_is(4'h0, 1'b0, 1'b0, 1'b0);
    tick(8'hAA);
    run_is(4'h0, 1'b0, 1'b0, 1'b0);
    // repeating run, 0x0010 gives a restart on the tenth tick
    host.write_reg(sched_pkg::RUN_PAGE, sched_pkg::DURATION_LO_OFS, 8'h01);
    host.write_reg(sched_pkg::RUN_PAGE, sched_pkg::REPEAT_LO_OFS, 8'h10);
    host.write_reg(sched_pkg::ACTION_PAGE, sched_pkg::AUX_RAIL_ACTION_OFS, sched_pkg::FLAG_ON);
    host.write_reg(sched_pkg::ACTION_PAGE, sched_pkg::RELAY_SET_ACTION_OFS, sched_pkg::FLAG_ON);
    tick(fld[0][0]);
    run_is(4'h1, 1'b1, 1'b1, 1'b1);
    for (int i = 1; i <= 10; i++) begin
      tick(8'hAA);
      chk_bit(entry_running[0], i == 10, "repeat restart");
    end
    host.write_reg(sched_pkg::ACTION_PAGE, sched_pkg::AUX_RAIL_ACTION_OFS, sched_pkg::FLAG_OFF);
    repeat (2) @(posedge clk);
    #1;
    run_is(4'h1, 1'b1, 1'b0, 1'b1);
    host.write_reg(sched_pkg::START_PAGE, sched_pkg::ACTIVE_OFS, sched_pkg::ACTIVE_STOP);
    repeat (2) @(posedge clk);
    #1;
    run_is(4'h0, 1'b0, 1'b0, 1'b0);
    tick(fld[0][0]);
    run_is(4'h0, 1'b0, 1'b0, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire

// file: test/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk,
  output logic      [7:0] page,
  output logic      [7:0] sub_addr,
  output logic            wr_en,
  output logic      [7:0] wr_data,
  output logic            rd_en,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  initial begin
    page = 8'h00;
    sub_addr = 8'h00;
    wr_en = 1'b0;
    wr_data = 8'h00;
    rd_en = 1'b0;
  end
  // released lines show the inverse so a stale address never passes
  task automatic write_reg(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    page <= p;
    sub_addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    page <= ~p;
    sub_addr <= ~a;
    wr_data <= ~d;
  endtask
  task automatic read_reg(input logic [7:0] p, input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    page <= p;
    sub_addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    page <= ~p;
    sub_addr <= ~a;
    #1;
    d = rd_data;
    v = rd_valid;
  endtask
endmodule
`default_nettype wire
